// File: design/eph_map.vh
// Purpose: Register map, bit map and timing counts of the energy preset handshake block.
// Assumes: APB with 32-bit data; register indices are word numbers, byte address is four times the index.
// Notes:   Overview of operation follows.
`ifndef EPH_MAP_VH
`define EPH_MAP_VH
// Register indices
`define EPH_IDX_TARGET     10'h033
`define EPH_IDX_VALUE_LO   10'h034
`define EPH_IDX_VALUE_HI   10'h035
`define EPH_IDX_REQUEST    10'h040
`define EPH_IDX_STATUS     10'h041
`define EPH_IDX_IRQ_STAT   10'h042
`define EPH_IDX_IRQ_MASK   10'h043
`define EPH_IDX_ACC_BASE   6'h05
`define EPH_ACC_COUNT      4'hc
// Reset values
`define EPH_RST_TARGET     16'h0000
`define EPH_RST_VALUE      16'h0000
// Handshake bit positions
`define EPH_BIT_READY      0
`define EPH_BIT_ACQ        1
`define EPH_BIT_COND       2
`define EPH_BIT_PRESET     3
`define EPH_BIT_CLEAR      4
`define EPH_BIT_CH1_BASE   5
`define EPH_BITS_PER_CH    6
`define EPH_BIT_FAULT      31
`define EPH_REQ_RSVD_MASK  32'h6000_0003
// Preset value limit
`define EPH_VALUE_MAX      32'h3b9a_c9ff
// Interrupt status bits
`define EPH_IRQ_DONE       0
`define EPH_IRQ_FAULT      1
// Cycles from reset release to module ready
`define EPH_READY_CYCLES   16
`endif

// File: design/eph_top.v
// Purpose: Preset handshake, status/request bit map and energy accumulators behind an APB slave.
// Assumes: Single 10 MHz clock; measurement logic supplies channel status and increment pulses.
// Notes:   APB answers with one wait state; read data is captured in the wait state, writes take effect on the pready edge.
//
// Chosen here: register access over APB.
`timescale 1ns/1ps
`include "eph_map.vh"
module eph_top #(
   parameter READY_CYCLES = `EPH_READY_CYCLES,
   parameter ACC_W        = 32
) (
   // Clock and reset
   input  wire              i_ref_clk,
   input  wire              i_arst_n,
   // APB slave
   input  wire              i_psel,
   input  wire              i_penable,
   input  wire              i_pwrite,
   input  wire [11:0]       i_paddr,
   input  wire [31:0]       i_pwdata,
   output reg  [31:0]       o_prdata,
   output reg               o_pready,
   output reg               o_pslverr,
   // Measurement side
   input  wire              i_hw_fault,
   input  wire              i_acq_strobe,
   input  wire [23:0]       i_chan_status,
   input  wire [11:0]       i_acc_inc,
   output reg  [31:0]       o_request,
   output reg  [31:0]       o_status,
   // Interrupt
   output reg               o_irq
);
   localparam S_IDLE = 3'b001;
   localparam S_LOAD = 3'b010;
   localparam S_DONE = 3'b100;

   // Accumulator index is (channel-1)*3 + (quantity-1)
   function [11:0] eph_sel;
      input [15:0] t;
      reg   [15:0] tens;
      reg   [15:0] units;
      reg   [3:0]  chm;
      reg   [2:0]  qm;
      integer      k;
      begin
         tens  = t / 16'd10;
         units = t % 16'd10;
         case (tens)
            16'd1:   chm = 4'h1;
            16'd2:   chm = 4'h2;
            16'd3:   chm = 4'h4;
            16'd4:   chm = 4'h8;
            16'd9:   chm = 4'hf;
            default: chm = 4'h0;
         endcase
         case (units)
            16'd1:   qm = 3'b001;
            16'd2:   qm = 3'b010;
            16'd3:   qm = 3'b100;
            16'd9:   qm = 3'b111;
            default: qm = 3'b000;
         endcase
         for (k = 0; k < 4; k = k + 1) begin
            eph_sel[k*3 +: 3] = chm[k] ? qm : 3'b000;
         end
      end
   endfunction

   // Code zero is a legal no-op: done is still given and nothing loads
   function eph_tgt_ok;
      input [15:0] t;
      begin
         eph_tgt_ok = (t == 16'h0000) || (eph_sel(t) != 12'h000);
      end
   endfunction

   reg  [15:0]      tgt_q;
   reg  [15:0]      vlo_q;
   reg  [15:0]      vhi_q;
   reg  [31:0]      req_q;
   reg  [1:0]       ist_q;
   reg  [1:0]       msk_q;
   reg  [ACC_W-1:0] acc_q [0:11];
   reg              preq_prev_q;
   reg  [2:0]       state_q;
   reg  [2:0]       state_d;
   reg              done_q;
   reg              fault_q;
   reg              cond_done_q;
   reg              clr_done_q;
   reg  [7:0]       rdy_cnt_q;
   reg              rdy_q;
   reg              hw_s1_q;
   reg              hw_s2_q;
   reg  [31:0]      rdata_d;
   reg              hit_d;
   reg  [31:0]      status_d;
   reg  [1:0]       ist_d;
   reg              fault_d;
   reg              oor_evt;
   reg              load_go;
   integer          i;
   integer          j;

   wire [9:0]  widx     = i_paddr[11:2];
   wire [3:0]  aidx     = widx[3:0];
   wire        acc_hit  = (widx[9:4] == `EPH_IDX_ACC_BASE) && (aidx < `EPH_ACC_COUNT);
   wire        apb_fire = i_psel & i_penable & o_pready;
   wire        acc_first = i_psel & i_penable & ~o_pready;
   wire        wr_fire  = apb_fire & i_pwrite;
   wire [31:0] value    = {vhi_q, vlo_q};
   wire [11:0] sel      = eph_sel(tgt_q);
   wire        preq     = req_q[`EPH_BIT_PRESET];
   wire        preq_rise = preq & ~preq_prev_q;

   // Register read mux and decode
   always @* begin
      rdata_d = 32'h0000_0000;
      hit_d   = 1'b1;
      case (widx)
         `EPH_IDX_TARGET:   rdata_d = {16'h0000, tgt_q};
         `EPH_IDX_VALUE_LO: rdata_d = {16'h0000, vlo_q};
         `EPH_IDX_VALUE_HI: rdata_d = {16'h0000, vhi_q};
         `EPH_IDX_REQUEST:  rdata_d = req_q;
         `EPH_IDX_STATUS:   rdata_d = o_status;
         `EPH_IDX_IRQ_STAT: rdata_d = {30'h0000_0000, ist_q};
         `EPH_IDX_IRQ_MASK: rdata_d = {30'h0000_0000, msk_q};
         default: begin
            if (acc_hit) begin
               rdata_d = acc_q[aidx];
            end else begin
               hit_d = 1'b0;
            end
         end
      endcase
   end

   // Preset sequencer
   always @* begin
      state_d = state_q;
      oor_evt = 1'b0;
      load_go = 1'b0;
      case (state_q)
         S_IDLE: begin
            if (preq_rise) begin
               state_d = S_LOAD;
            end
         end
         S_LOAD: begin
            // Range is checked here too, so a host that skips its own limit cannot load junk
            if (eph_tgt_ok(tgt_q) && (value <= `EPH_VALUE_MAX)) begin
               load_go = 1'b1;
            end else begin
               oor_evt = 1'b1;
            end
            state_d = S_DONE;
         end
         S_DONE: begin
            // A request held high keeps done up and cannot retrigger
            if (!preq) begin
               state_d = S_IDLE;
            end
         end
         default: state_d = S_IDLE;
      endcase
   end

   // Status word assembly
   always @* begin
      status_d = 32'h0000_0000;
      status_d[`EPH_BIT_READY]  = rdy_q;
      status_d[`EPH_BIT_ACQ]    = i_acq_strobe;
      status_d[`EPH_BIT_COND]   = cond_done_q;
      status_d[`EPH_BIT_PRESET] = done_q;
      status_d[`EPH_BIT_CLEAR]  = clr_done_q;
      for (i = 0; i < 4; i = i + 1) begin
         status_d[`EPH_BIT_CH1_BASE + i*`EPH_BITS_PER_CH +: 6] = i_chan_status[i*6 +: 6];
      end
      // Bits 29 and 30 stay zero; software must ignore them
      status_d[`EPH_BIT_FAULT]  = fault_q;
   end

   // Set wins over the clear for the fault flag and sticky interrupt bits
   always @* begin
      // Clear request acts as a level: holding it keeps clearing until a new fault
      fault_d = hw_s2_q | oor_evt | (fault_q & ~req_q[`EPH_BIT_FAULT]);
      ist_d   = ist_q;
      if (wr_fire && (widx == `EPH_IDX_IRQ_STAT)) begin
         ist_d = ist_q & ~i_pwdata[1:0];
      end
      if (state_q == S_LOAD) begin
         ist_d[`EPH_IRQ_DONE] = 1'b1;
      end
      if (fault_d && !fault_q) begin
         ist_d[`EPH_IRQ_FAULT] = 1'b1;
      end
   end

   // One wait state keeps pready and prdata straight from flops
   always @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_prdata  <= 32'h0000_0000;
         o_pready  <= 1'b0;
         o_pslverr <= 1'b0;
      end else begin
         o_pready  <= acc_first;
         o_pslverr <= acc_first & ~hit_d;
         o_prdata  <= (acc_first & ~i_pwrite) ? rdata_d : 32'h0000_0000;
      end
   end

   // Writes land on the edge where pready is seen high, never in the wait state
   always @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         tgt_q     <= `EPH_RST_TARGET;
         vlo_q     <= `EPH_RST_VALUE;
         vhi_q     <= `EPH_RST_VALUE;
         req_q     <= 32'h0000_0000;
         msk_q     <= 2'b00;
         ist_q     <= 2'b00;
      end else begin
         ist_q     <= ist_d;
         // Reserved request bits are dropped here, whatever the host writes
         if (wr_fire) begin
            case (widx)
               `EPH_IDX_TARGET:   tgt_q <= i_pwdata[15:0];
               `EPH_IDX_VALUE_LO: vlo_q <= i_pwdata[15:0];
               `EPH_IDX_VALUE_HI: vhi_q <= i_pwdata[15:0];
               `EPH_IDX_REQUEST:  req_q <= i_pwdata & ~`EPH_REQ_RSVD_MASK;
               `EPH_IDX_IRQ_MASK: msk_q <= i_pwdata[1:0];
               default: ;
            endcase
         end
      end
   end

   // Accumulators: preset load takes priority over counting
   always @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         for (j = 0; j < 12; j = j + 1) begin
            acc_q[j] <= {ACC_W{1'b0}};
         end
      end else begin
         // A count that meets a load is lost; the preset value wins
         for (j = 0; j < 12; j = j + 1) begin
            if (load_go && sel[j]) begin
               acc_q[j] <= value[ACC_W-1:0];
            end else if (i_acc_inc[j]) begin
               acc_q[j] <= acc_q[j] + {{(ACC_W-1){1'b0}}, 1'b1};
            end
         end
      end
   end

   // Only the second stage is read, so a metastable first stage never reaches logic
   always @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         hw_s1_q     <= 1'b0;
         hw_s2_q     <= 1'b0;
      end else begin
         hw_s1_q     <= i_hw_fault;
         hw_s2_q     <= hw_s1_q;
      end
   end

   // Counter saturates, so ready returns as soon as a hardware fault goes away
   always @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         rdy_cnt_q   <= 8'h00;
         rdy_q       <= 1'b0;
      end else begin
         if (rdy_cnt_q != READY_CYCLES[7:0]) begin
            rdy_cnt_q <= rdy_cnt_q + 8'h01;
         end
         rdy_q       <= (rdy_cnt_q == READY_CYCLES[7:0]) & ~hw_s2_q;
      end
   end

   // Handshake state, status word and interrupt
   always @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         state_q     <= S_IDLE;
         done_q      <= 1'b0;
         preq_prev_q <= 1'b0;
         fault_q     <= 1'b0;
         cond_done_q <= 1'b0;
         clr_done_q  <= 1'b0;
         o_request   <= 32'h0000_0000;
         o_status    <= 32'h0000_0000;
         o_irq       <= 1'b0;
      end else begin
         state_q     <= state_d;
         // Done comes from the next state so it rises with the state change
         done_q      <= (state_d == S_DONE);
         preq_prev_q <= preq;
         fault_q     <= fault_d;
         cond_done_q <= req_q[`EPH_BIT_COND];
         clr_done_q  <= req_q[`EPH_BIT_CLEAR];
         o_request   <= req_q;
         o_status    <= status_d;
         o_irq       <= |(ist_d & msk_q);
      end
   end
endmodule

// File: verif/eph_top_chk_sva.sv
// Purpose: Port-level checks of the preset handshake block.
// Assumes: Bound into every eph_top instance.
// Notes:   Internal state is not visible; only port relations are checked.
`timescale 1ns/1ps
module eph_top_chk (
   // Clock and reset
   input wire        i_ref_clk,
   input wire        i_arst_n,
   // Watched ports
   input wire        i_psel,
   input wire        i_penable,
   input wire        i_hw_fault,
   input wire        i_acq_strobe,
   input wire [23:0] i_chan_status,
   input wire        o_pready,
   input wire        o_pslverr,
   input wire [31:0] o_request,
   input wire [31:0] o_status,
   input wire        o_irq
);
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_arst_n);
   apb_wait_a: assert property (i_psel && i_penable && !o_pready |=> o_pready)
      else $error("pready late");
   apb_pulse_a: assert property (o_pready |=> !o_pready)
      else $error("pready too long");
   err_ready_a: assert property (o_pslverr |-> o_pready)
      else $error("pslverr without pready");
   done_cause_a: assert property ($rose(o_status[3]) |-> o_request[3])
      else $error("done without request");
   done_drop_a: assert property ($fell(o_request[3]) |-> ##[0:3] !o_status[3])
      else $error("done stuck");
   done_hold_a: assert property (o_request[3] && $past(o_status[3]) |-> o_status[3])
      else $error("done dropped early");
   req_rsvd_a: assert property (o_request[1:0] == 2'b00 && o_request[30:29] == 2'b00)
      else $error("reserved request bit");
   acq_copy_a: assert property (o_status[1] == $past(i_acq_strobe))
      else $error("acq bit wrong");
   chan_map_a: assert property ($stable(i_chan_status) |-> o_status[28:5] == i_chan_status)
      else $error("channel bits wrong");
   hw_fault_a: assert property (i_hw_fault [*5] |-> o_status[31] && !o_status[0])
      else $error("hw fault not shown");
   cover property ($rose(o_status[3]));
   cover property (o_pslverr);
   cover property (o_irq);
   cover property ($fell(o_status[31]));
endmodule
bind eph_top eph_top_chk eph_top_chk_inst (
   .i_ref_clk     (i_ref_clk),
   .i_arst_n      (i_arst_n),
   .i_psel        (i_psel),
   .i_penable     (i_penable),
   .i_hw_fault    (i_hw_fault),
   .i_acq_strobe  (i_acq_strobe),
   .i_chan_status (i_chan_status),
   .o_pready      (o_pready),
   .o_pslverr     (o_pslverr),
   .o_request     (o_request),
   .o_status      (o_status),
   .o_irq         (o_irq)
);

// File: verif/eph_host.sv
// Purpose: Host model that drives the APB side of the preset block.
// Assumes: One clock; one transfer at a time.
// Notes:   Released address and data are inverted so stale values never look valid.
`timescale 1ns/1ps
module eph_host (
   // Clock
   input  wire        i_ref_clk,
   // Slave answer
   input  wire        i_pready,
   input  wire        i_pslverr,
   input  wire [31:0] i_prdata,
   // Request
   output reg         o_psel,
   output reg         o_penable,
   output reg         o_pwrite,
   output reg  [11:0] o_paddr,
   output reg  [31:0] o_pwdata
);
   initial begin
      o_psel = 1'b0;
      o_penable = 1'b0;
      o_pwrite = 1'b0;
      o_paddr = 12'h000;
      o_pwdata = 32'h0000_0000;
   end
   // Callers never set reserved request bits
   task xfer(input w, input [11:0] a, input [31:0] d, output [31:0] q, output e, output t);
      integer n;
      begin
         n = 0;
         @(posedge i_ref_clk);
         o_psel <= 1'b1;
         o_pwrite <= w;
         o_paddr <= a;
         o_pwdata <= d;
         @(posedge i_ref_clk);
         o_penable <= 1'b1;
         do begin
            @(posedge i_ref_clk);
            n = n + 1;
         end while (i_pready !== 1'b1 && n < 20);
         q = i_prdata;
         e = i_pslverr;
         t = (n >= 20);
         o_psel <= 1'b0;
         o_penable <= 1'b0;
         o_paddr <= ~a;
         o_pwdata <= ~d;
      end
   endtask
endmodule

// File: verif/energy_preset_handshake_tb_top.sv
// Purpose: Register-level regression of the preset handshake block.
// Assumes: Ready count shortened to 2; increments tied off.
// Notes:   Expected accumulators are kept in a local table.
`timescale 1ns/1ps
module energy_preset_handshake_tb_top;
   reg         i_ref_clk, i_arst_n, i_hw_fault, i_acq_strobe;
   reg  [23:0] i_chan_status;
   wire        i_psel, i_penable, i_pwrite, o_pready, o_pslverr, o_irq;
   wire [11:0] i_paddr;
   wire [31:0] i_pwdata, o_prdata, o_request, o_status;
   reg  [31:0] q, v;
   reg  [31:0] ex [0:11];
   reg         e, t;
   integer     fails, num_checks, c, k, i, ch;
   eph_top #(.READY_CYCLES(2)) eph_top_inst (.i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n), .i_psel(i_psel),
      .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
      .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr), .i_hw_fault(i_hw_fault),
      .i_acq_strobe(i_acq_strobe), .i_chan_status(i_chan_status), .i_acc_inc(12'h000),
      .o_request(o_request), .o_status(o_status), .o_irq(o_irq));
   eph_host eph_host_inst (.i_ref_clk(i_ref_clk), .i_pready(o_pready), .i_pslverr(o_pslverr),
      .i_prdata(o_prdata), .o_psel(i_psel), .o_penable(i_penable), .o_pwrite(i_pwrite),
      .o_paddr(i_paddr), .o_pwdata(i_pwdata));
   always #50 i_ref_clk = ~i_ref_clk;
   task wrap_up;
      begin
         $display("checks %0d fails %0d", num_checks, fails);
         if (fails == 0 && num_checks > 0) $display("Regression OK");
         else $display("Regression broken");
         $finish;
      end
   endtask
   task chk(input [31:0] got, input [31:0] want);
      begin
         num_checks = num_checks + 1;
         if (got !== want) begin
            fails = fails + 1;
            $display("unexpected at %0t: got %h want %h", $time, got, want);
         end
      end
   endtask
   task acc(input w, input [11:0] a, input [31:0] d);
      begin
         eph_host_inst.xfer(w, a, d, q, e, t);
         if (t) begin
            fails = fails + 1;
            $display("unexpected at %0t: no pready", $time);
            wrap_up;
         end
      end
   endtask
   task wait_stat(input integer b, input x);
      integer n;
      begin
         n = 0;
         do begin
            acc(0, 12'h104, 0);
            n = n + 1;
         end while (q[b] !== x && n < 40);
         chk(q[b], x);
         if (q[b] !== x) wrap_up;
      end
   endtask
   task preset(input [15:0] cd, input [31:0] pv);
      begin
         acc(1, 12'h0cc, {16'h0, cd});
         acc(1, 12'h0d0, {16'h0, pv[15:0]});
         acc(1, 12'h0d4, {16'h0, pv[31:16]});
         acc(1, 12'h100, 32'h8);
         wait_stat(3, 1'b1);
         acc(1, 12'h100, 32'h0);
         wait_stat(3, 1'b0);
      end
   endtask
   task accs;
      for (i = 0; i < 12; i = i + 1) begin
         acc(0, 12'h140 + 4 * i, 0);
         chk(q, ex[i]);
      end
   endtask
   initial begin
      {i_ref_clk, i_arst_n, i_hw_fault, i_acq_strobe, i_chan_status} = 0;
      fails = 0;
      num_checks = 0;
      for (i = 0; i < 12; i = i + 1) ex[i] = 0;
      repeat (6) @(posedge i_ref_clk);
      i_arst_n <= 1'b1;
      for (k = 0; k < 3; k = k + 1) begin
         acc(0, 12'h0cc + 4 * k, 0);
         chk(q, 0);
      end
      wait_stat(0, 1'b1);
      $display("reset test done");
      for (c = 0; c < 5; c = c + 1) for (k = 1; k < 5; k = k + 1) begin
         ch = (c == 4) ? 9 : c + 1;
         v = (ch == 9 && k == 4) ? 32'h3b9a_c9ff : (ch * 10 + k) * 1000 + 7;
         for (i = 0; i < 12; i = i + 1)
            if ((ch == 9 || i / 3 == ch - 1) && (k == 4 || i % 3 == k - 1)) ex[i] = v;
         preset(ch * 10 + ((k == 4) ? 9 : k), v);
         accs;
      end
      $display("target code test done");
      chk(o_irq, 0);
      acc(1, 12'h10c, 32'h1);
      repeat (2) @(posedge i_ref_clk);
      chk(o_irq, 1);
      acc(1, 12'h108, 32'h3);
      repeat (2) @(posedge i_ref_clk);
      chk(o_irq, 0);
      $display("irq test done");
      acc(1, 12'h100, 32'h14);
      wait_stat(2, 1'b1);
      chk(q[4], 1);
      acc(1, 12'h100, 32'h0);
      wait_stat(2, 1'b0);
      chk(q[4], 0);
      $display("handshake map test done");
      preset(14, 5);
      accs;
      wait_stat(31, 1'b1);
      acc(0, 12'h108, 0);
      chk(q, 32'h3);
      chk(o_irq, 1);
      acc(1, 12'h100, 32'h8000_0000);
      wait_stat(31, 1'b0);
      i_hw_fault <= 1'b1;
      i_acq_strobe <= 1'b1;
      i_chan_status <= 24'ha5c3f0;
      wait_stat(31, 1'b1);
      chk(q[0], 0);
      chk(q[1], 1);
      chk(q[28:5], 24'ha5c3f0);
      i_hw_fault <= 1'b0;
      wait_stat(31, 1'b0);
      wait_stat(0, 1'b1);
      acc(1, 12'h100, 32'h0);
      $display("fault test done");
      acc(0, 12'h3fc, 0);
      chk(e, 1);
      chk(q, 0);
      $display("bus test done");
      wrap_up;
   end
endmodule
